// ==== crs_top.sv ====
// configuration reload, regulator start-up and sleep sequencing
// ==========================================================
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "crs_consts.svh"

module crs_top
#(
	parameter int POWERUP_DELAY_TIMER_CYC = `CRS_POWERUP_DELAY_TIMER_CYC
)
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire crs_pkg::crs_apb_req_t apb_i,
	output var crs_pkg::crs_apb_rsp_t apb_o,
	input wire logic por_i,
	input wire logic other_reset_i,
	input wire logic bor_detect_i,
	input wire logic regulator_en_i,
	input wire logic sleep_i,
	input wire logic wake_i,
	output logic flash_req_o,
	output logic [23:0] flash_addr_o,
	input wire logic flash_ack_i,
	input wire logic [23:0] flash_data_i,
	input wire logic tbl_rd_i,
	input wire logic [23:0] tbl_addr_i,
	output logic [23:0] tbl_data_o,
	output logic core_reset_o,
	output logic exec_en_o,
	output logic reg_standby_o,
	output logic flash_pwr_o,
	output logic code_protect_o,
	output logic irq_o
);

	// ==========================================================
	// functions
	function automatic logic [23:0] pick_delay(input crs_pkg::crs_dly_t k);
		logic [23:0] d;
		d = 24'h0;
		if (k == crs_pkg::CRS_DLY_SETTLE)
			d = 24'(`CRS_SETTLE_CYC);
		else if (k == crs_pkg::CRS_DLY_POWERUP_DELAY_TIMER)
			d = 24'(POWERUP_DELAY_TIMER_CYC);
		return d;
	endfunction

	function automatic crs_pkg::crs_dly_t wake_kind(input logic reg_en,
		input logic keep);
		crs_pkg::crs_dly_t k;
		k = crs_pkg::CRS_DLY_SETTLE;
		if (keep)
			k = crs_pkg::CRS_DLY_NONE;
		return k;
	endfunction

	// ==========================================================
	// state
	crs_pkg::crs_regs_t r_reg;
	crs_pkg::crs_regs_t r_next;
	localparam crs_pkg::crs_regs_t RST_VAL = '{
		fsm: crs_pkg::CRS_LOAD,
		dly: crs_pkg::CRS_DLY_POWERUP_DELAY_TIMER,
		cnt: 24'h0,
		idx: 2'h0,
		cfg: {3{`CRS_CFG_RST}},
		keep: 1'b0,
		bor_flag: 1'b0,
		por_flag: 1'b1,
		ists: 3'h0,
		ien: 3'h0,
		rsp: '0,
		irq: 1'b0,
		core_reset: 1'b1,
		exec_en: 1'b0,
		reg_standby: 1'b0,
		flash_pwr: 1'b1,
		flash_req: 1'b1,
		flash_addr: `CRS_FLASH_WORD1,
		tbl_data: 24'h0,
		code_protect: 1'b0
	};

	logic rst_evt;
	logic bor_evt;
	logic acc;
	logic [23:0] d;
	logic [23:0] toff;

	assign bor_evt = bor_detect_i & regulator_en_i;
	assign rst_evt = por_i | other_reset_i | bor_evt;
	assign acc = apb_i.psel & apb_i.penable & r_reg.rsp.pready;

	// ==========================================================
	// next state
	always_comb
	begin
		r_next = r_reg;
		d = 24'h0;
		toff = tbl_addr_i - `CRS_CFG_BASE;
		// apb access: pready one cycle into access phase
		r_next.rsp.pready = apb_i.psel & apb_i.penable & ~r_reg.rsp.pready;
		if (r_next.rsp.pready)
		begin
			r_next.rsp.pslverr = 1'b0;
			r_next.rsp.prdata = 32'h0;
			unique case (apb_i.paddr)
				`CRS_OFF_RCTL:
				begin
					r_next.rsp.prdata[`CRS_KEEP_BIT] = r_reg.keep;
					r_next.rsp.prdata[`CRS_BOR_BIT] = r_reg.bor_flag;
					r_next.rsp.prdata[`CRS_POR_BIT] = r_reg.por_flag;
				end
				`CRS_OFF_CFG0, `CRS_OFF_CFG1, `CRS_OFF_CFG2:
					r_next.rsp.prdata[23:0] = {`CRS_UPPER_BYTE,
						r_reg.cfg[apb_i.paddr[3:2] - 2'h1]};
				`CRS_OFF_ISTS:
					r_next.rsp.prdata[2:0] = r_reg.ists;
				`CRS_OFF_ICLR:
					r_next.rsp.prdata = 32'h0;
				`CRS_OFF_IEN:
					r_next.rsp.prdata[2:0] = r_reg.ien;
				`CRS_OFF_STAT:
					r_next.rsp.prdata[3:0] = {r_reg.core_reset, r_reg.fsm};
				default:
					r_next.rsp.pslverr = 1'b1;
			endcase
		end
		if (acc && apb_i.pwrite)
		begin
			unique case (apb_i.paddr)
				`CRS_OFF_RCTL:
				begin
					r_next.keep = apb_i.pwdata[`CRS_KEEP_BIT];
					r_next.bor_flag = r_reg.bor_flag
						& apb_i.pwdata[`CRS_BOR_BIT];
					r_next.por_flag = r_reg.por_flag
						& apb_i.pwdata[`CRS_POR_BIT];
				end
				`CRS_OFF_ICLR:
					r_next.ists = r_reg.ists & ~apb_i.pwdata[2:0];
				`CRS_OFF_IEN:
					r_next.ien = apb_i.pwdata[2:0];
				default:
					r_next.ien = r_next.ien;
			endcase
		end

		// configuration space reads through the table port; apb also reads the cfg words
		if (tbl_rd_i)
		begin
			if (tbl_addr_i[23:16] < `CRS_CFG_SPACE_TOP)
				r_next.tbl_data = 24'h0;
			else if (toff < 24'(2 * `CRS_CFG_WORDS) && !toff[0])
				r_next.tbl_data = {`CRS_UPPER_BYTE,
					r_reg.cfg[toff[2:1]]};
			else
				r_next.tbl_data = 24'hffffff;
		end

		// sequencer; hardware sets win over software clears
		if (rst_evt)
		begin
			r_next.fsm = crs_pkg::CRS_LOAD;
			r_next.idx = 2'h0;
			r_next.flash_req = 1'b1;
			r_next.flash_addr = `CRS_FLASH_WORD1;
			if (por_i || bor_evt)
				r_next.dly = regulator_en_i ? crs_pkg::CRS_DLY_SETTLE
					: crs_pkg::CRS_DLY_POWERUP_DELAY_TIMER;
			else
				r_next.dly = crs_pkg::CRS_DLY_NONE;
			if (bor_evt)
			begin
				r_next.bor_flag = 1'b1;
				r_next.ists[`CRS_EV_BOR] = 1'b1;
			end
			if (por_i)
				r_next.por_flag = 1'b1;
		end
		else
		begin
			unique case (r_reg.fsm)
				crs_pkg::CRS_LOAD:
				begin
					if (flash_ack_i)
					begin
						// upper byte dropped, only 16 bits are implemented
						r_next.cfg[r_reg.idx] = flash_data_i[15:0];
						r_next.idx = r_reg.idx + 2'h1;
						r_next.flash_addr = r_reg.flash_addr - 24'h2;
						if (r_reg.idx == `CRS_CFG_LAST)
						begin
							r_next.flash_req = 1'b0;
							r_next.ists[`CRS_EV_LOAD] = 1'b1;
							d = pick_delay(r_reg.dly);
							r_next.cnt = d;
							r_next.fsm = (d == 24'h0) ? crs_pkg::CRS_RUN
								: crs_pkg::CRS_DELAY;
						end
					end
				end
				crs_pkg::CRS_DELAY:
				begin
					r_next.cnt = r_reg.cnt - 24'h1;
					if (r_reg.cnt == 24'h1)
						r_next.fsm = crs_pkg::CRS_RUN;
				end
				crs_pkg::CRS_RUN:
				begin
					if (sleep_i)
						r_next.fsm = crs_pkg::CRS_SLEEP;
				end
				crs_pkg::CRS_SLEEP:
				begin
					if (wake_i)
					begin
						if (regulator_en_i)
							d = pick_delay(wake_kind(1'b1, r_reg.keep));
						else if (r_reg.keep)
							d = 24'(`CRS_FAST_CYC);
						else
							d = 24'(`CRS_SETTLE_CYC);
						r_next.cnt = d;
						if (d == 24'h0)
						begin
							r_next.fsm = crs_pkg::CRS_RUN;
							r_next.ists[`CRS_EV_WAKE] = 1'b1;
						end
						else
							r_next.fsm = crs_pkg::CRS_WAKE;
					end
				end
				crs_pkg::CRS_WAKE:
				begin
					r_next.cnt = r_reg.cnt - 24'h1;
					if (r_reg.cnt == 24'h1)
					begin
						r_next.fsm = crs_pkg::CRS_RUN;
						r_next.ists[`CRS_EV_WAKE] = 1'b1;
					end
				end
			endcase
		end

		// registered outputs from next state
		r_next.core_reset = (r_next.fsm == crs_pkg::CRS_LOAD)
			|| (r_next.fsm == crs_pkg::CRS_DELAY);
		r_next.exec_en = r_next.fsm == crs_pkg::CRS_RUN;
		r_next.reg_standby = (r_next.fsm == crs_pkg::CRS_SLEEP)
			&& regulator_en_i && !r_next.keep;
		r_next.flash_pwr = !r_next.reg_standby;
		r_next.code_protect = !r_next.cfg[0][`CRS_CP_BIT];
		r_next.irq = |(r_next.ists & r_next.ien);
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			r_reg <= RST_VAL;
		else if (ce_i)
			r_reg <= r_next;
	end

	assign apb_o = r_reg.rsp;
	assign flash_req_o = r_reg.flash_req;
	assign flash_addr_o = r_reg.flash_addr;
	assign tbl_data_o = r_reg.tbl_data;
	assign core_reset_o = r_reg.core_reset;
	assign exec_en_o = r_reg.exec_en;
	assign reg_standby_o = r_reg.reg_standby;
	assign flash_pwr_o = r_reg.flash_pwr;
	assign code_protect_o = r_reg.code_protect;
	assign irq_o = r_reg.irq;

	// ==========================================================
	// checks
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i || !ce_i);

	sequence slow_wake_s;
		r_reg.fsm == crs_pkg::CRS_SLEEP && wake_i && !rst_evt
			&& regulator_en_i && !r_reg.keep;
	endsequence

	sequence held_s;
		r_reg.fsm == crs_pkg::CRS_WAKE && !exec_en_o;
	endsequence

	chk_core_held: assert property (
		(r_reg.fsm == crs_pkg::CRS_LOAD || r_reg.fsm == crs_pkg::CRS_DELAY)
			|-> core_reset_o && !exec_en_o)
		else $error("core not held during load or delay");
	chk_bor_flag_set: assert property (
		bor_detect_i && regulator_en_i |=> r_reg.bor_flag && core_reset_o)
		else $error("brown-out not flagged");
	chk_cfg_reload: assert property (
		rst_evt |=> r_reg.fsm == crs_pkg::CRS_LOAD && flash_req_o
			&& flash_addr_o == `CRS_FLASH_WORD1)
		else $error("reset did not restart reload");
	chk_settle_wait: assert property (
		slow_wake_s |=> held_s [*8])
		else $error("settle delay cut short");
	chk_fast_wake: assert property (
		r_reg.fsm == crs_pkg::CRS_SLEEP && wake_i && !rst_evt
			&& regulator_en_i && r_reg.keep |=> exec_en_o)
		else $error("fast wake delayed");
	chk_standby_out: assert property (
		r_reg.fsm == crs_pkg::CRS_SLEEP && regulator_en_i && !r_reg.keep
			|-> reg_standby_o && !flash_pwr_o)
		else $error("standby not entered");
	chk_upper_byte: assert property (
		tbl_rd_i && tbl_addr_i == `CRS_CFG_BASE
			|=> tbl_data_o[23:16] == `CRS_UPPER_BYTE)
		else $error("upper byte not all ones");
	chk_powerup_delay_timer_load: assert property (
		por_i && !regulator_en_i ##1 !rst_evt [*1] ##0
			r_reg.fsm == crs_pkg::CRS_LOAD
			|-> r_reg.dly == crs_pkg::CRS_DLY_POWERUP_DELAY_TIMER)
		else $error("power-up timer not chosen");
	chk_keep_write: assert property (
		acc && apb_i.pwrite && apb_i.paddr == `CRS_OFF_RCTL
			|=> r_reg.keep == $past(apb_i.pwdata[`CRS_KEEP_BIT]))
		else $error("keep bit not written");

endmodule

`default_nettype wire

// ==== crs_consts.svh ====
// offsets, field positions, reset values and timing counts for crs
`ifndef CRS_CONSTS_SVH
`define CRS_CONSTS_SVH

// ==========================================================
// register offsets (byte addresses)
`define CRS_OFF_RCTL 8'h00
`define CRS_OFF_CFG0 8'h04
`define CRS_OFF_CFG1 8'h08
`define CRS_OFF_CFG2 8'h0c
`define CRS_OFF_ISTS 8'h10
`define CRS_OFF_ICLR 8'h14
`define CRS_OFF_IEN 8'h18
`define CRS_OFF_STAT 8'h1c

// ==========================================================
// field positions
`define CRS_KEEP_BIT 8
`define CRS_BOR_BIT 1
`define CRS_POR_BIT 0
`define CRS_CP_BIT 15
`define CRS_EV_LOAD 0
`define CRS_EV_BOR 1
`define CRS_EV_WAKE 2

// ==========================================================
// configuration space
`define CRS_CFG_BASE 24'hf80000
`define CRS_CFG_SPACE_TOP 8'h80
`define CRS_CFG_WORDS 3
`define CRS_CFG_LAST 2'h2
`define CRS_FLASH_WORD1 24'h2abfe
`define CRS_CFG_RST 16'hffff
`define CRS_UPPER_BYTE 8'hff

// ==========================================================
// timing
`define CRS_CLK_MHZ 250
`define CRS_SETTLE_NS 10000
`define CRS_SETTLE_CYC ((`CRS_SETTLE_NS * `CRS_CLK_MHZ) / 1000)
`define CRS_FAST_WAKE_NS 1000
`define CRS_FAST_CYC ((`CRS_FAST_WAKE_NS * `CRS_CLK_MHZ) / 1000)
`define CRS_POWERUP_DELAY_TIMER_MS 64
`define CRS_POWERUP_DELAY_TIMER_CYC (`CRS_POWERUP_DELAY_TIMER_MS * `CRS_CLK_MHZ * 1000)

`endif

// ==== crs_pkg.sv ====
// types for the configuration load and regulator start-up block
`default_nettype none

package crs_pkg;

	typedef enum logic [2:0]
	{
		CRS_LOAD = 3'h0,
		CRS_DELAY = 3'h1,
		CRS_RUN = 3'h3,
		CRS_SLEEP = 3'h2,
		CRS_WAKE = 3'h6
	} crs_state_t;

	typedef enum logic [1:0]
	{
		CRS_DLY_NONE = 2'h0,
		CRS_DLY_SETTLE = 2'h1,
		CRS_DLY_POWERUP_DELAY_TIMER = 2'h2
	} crs_dly_t;

	typedef struct packed
	{
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} crs_apb_req_t;

	typedef struct packed
	{
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} crs_apb_rsp_t;

	typedef struct packed
	{
		crs_state_t fsm;
		crs_dly_t dly;
		logic [23:0] cnt;
		logic [1:0] idx;
		logic [2:0][15:0] cfg;
		logic keep;
		logic bor_flag;
		logic por_flag;
		logic [2:0] ists;
		logic [2:0] ien;
		crs_apb_rsp_t rsp;
		logic irq;
		logic core_reset;
		logic exec_en;
		logic reg_standby;
		logic flash_pwr;
		logic flash_req;
		logic [23:0] flash_addr;
		logic [23:0] tbl_data;
		logic code_protect;
	} crs_regs_t;

endpackage

`default_nettype wire

// ==== crs_flash_model.sv ====
// flash model that answers configuration reload requests
`timescale 1ns/100ps
`default_nettype none

module crs_flash_model
(
	input wire logic clock_i,
	input wire logic req_i,
	input wire logic [23:0] addr_i,
	input wire logic erase_i,
	output logic ack_o,
	output logic [23:0] data_o
);
	logic [15:0] w [3] = '{16'hf3c5, 16'h5a96, 16'hc0de};
	logic [1:0] gap = 2'h0;
	logic [1:0] idx;
	assign idx = 2'((24'h2abfe - addr_i) >> 1);
	// ==========================================================
	// answer with a gap on alternate cycles
	always @(posedge clock_i)
	begin
		gap <= gap + 2'h1;
		if (erase_i)
			w <= '{default: 16'h0000};
		if (req_i && !ack_o && gap[0])
		begin
			ack_o <= 1'b1;
			data_o <= {8'hff, w[idx]};
		end
		else
		begin
			ack_o <= 1'b0;
			data_o <= ~data_o;
		end
	end
endmodule

`default_nettype wire

// ==== config_load_and_regulator_startup_tb.sv ====
// self-checking bench for the start-up sequencer
`timescale 1ns/100ps
`default_nettype none
`include "crs_consts.svh"

module config_load_and_regulator_startup_tb;
	logic clock_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic por_i = 1'b0;
	logic bor_i = 1'b0;
	logic ren = 1'b1;
	logic slp = 1'b0;
	logic wak = 1'b0;
	logic ers = 1'b0;
	logic trd = 1'b0;
	logic orst = 1'b0;
	logic ce = 1'b1;
	logic [23:0] tad = 24'h000000;
	crs_pkg::crs_apb_req_t req = '0;
	crs_pkg::crs_apb_rsp_t rsp;
	logic freq, fack, crst, exe, stby, fpwr, cprot, irq;
	logic [23:0] fadr, fdat, tdat;
	logic [31:0] rd;
	logic er;
	int err_count = 0;
	int n_compared = 0;
	int n;
	typedef struct {logic [7:0] o; logic [23:0] t;
		logic [31:0] ea; logic [23:0] et;} crs_row_t;
	crs_row_t rows [5];
	typedef struct {logic r; logic k; logic s; int lo; int hi;} crs_slp_t;
	crs_slp_t srow [4];

	initial
	begin
		forever #2 clock_i = ~clock_i;
	end

	crs_top #(.POWERUP_DELAY_TIMER_CYC(20)) u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.ce_i(ce), .apb_i(req), .apb_o(rsp), .por_i(por_i),
		.other_reset_i(orst), .bor_detect_i(bor_i), .regulator_en_i(ren),
		.sleep_i(slp), .wake_i(wak), .flash_req_o(freq),
		.flash_addr_o(fadr), .flash_ack_i(fack), .flash_data_i(fdat),
		.tbl_rd_i(trd), .tbl_addr_i(tad), .tbl_data_o(tdat),
		.core_reset_o(crst), .exec_en_o(exe), .reg_standby_o(stby),
		.flash_pwr_o(fpwr), .code_protect_o(cprot), .irq_o(irq));

	crs_flash_model u_fl (.clock_i(clock_i), .req_i(freq), .addr_i(fadr),
		.erase_i(ers), .ack_o(fack), .data_o(fdat));

	// ==========================================================
	// tasks
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clock_i);
		req.penable <= 1'b1;
		@(posedge clock_i);
		while (rsp.pready !== 1'b1)
			@(posedge clock_i);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
	endtask

	task tbl(input logic [23:0] a);
		@(posedge clock_i);
		trd <= 1'b1;
		tad <= a;
		@(posedge clock_i);
		trd <= 1'b0;
		@(posedge clock_i);
	endtask

	task pulse(input int s);
		@(posedge clock_i);
		case (s)
			0: bor_i <= 1'b1;
			1: slp <= 1'b1;
			2: wak <= 1'b1;
			3: ers <= 1'b1;
			4: por_i <= 1'b1;
			default: orst <= 1'b1;
		endcase
		@(posedge clock_i);
		bor_i <= 1'b0;
		slp <= 1'b0;
		wak <= 1'b0;
		ers <= 1'b0;
		por_i <= 1'b0;
		orst <= 1'b0;
	endtask

	task wait_run(output int c);
		c = 0;
		while (exe !== 1'b1 && c < 6000)
		begin
			@(posedge clock_i);
			c++;
		end
	endtask

	task tally_and_finish;
		$display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		repeat (40000) @(posedge clock_i);
		err_count++;
		tally_and_finish;
	end

	// ==========================================================
	// main sequence
	initial
	begin
		rows = '{'{`CRS_OFF_CFG0, 24'hf80000, 32'h00fff3c5, 24'hfff3c5},
			'{`CRS_OFF_CFG1, 24'hf80002, 32'h00ff5a96, 24'hff5a96},
			'{`CRS_OFF_CFG2, 24'hf80004, 32'h00ffc0de, 24'hffc0de},
			'{`CRS_OFF_STAT, 24'h800000, 32'h00000003, 24'hffffff},
			'{`CRS_OFF_IEN, 24'h012345, 32'h00000000, 24'h000000}};
		srow = '{'{1'b1, 1'b0, 1'b1, 2500, 2512}, '{1'b1, 1'b1, 1'b0, 0, 4},
			'{1'b0, 1'b0, 1'b0, 2500, 2512}, '{1'b0, 1'b1, 1'b0, 250, 262}};
		repeat (6) @(posedge clock_i);
		rst_b_i <= 1'b1;
		@(posedge clock_i);
		chk("core_reset", 1, crst);
		wait_run(n);
		chk("powerup_delay_timer_start", 1, n >= 20 && n <= 60);
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b0, rows[i].o, 32'h0);
			chk("apb_rd", rows[i].ea, rd);
			tbl(rows[i].t);
			chk("tbl_rd", rows[i].et, tdat);
		end
		apb(1'b0, 8'h20, 32'h0);
		chk("slverr", 1, er);
		// brown-out with regulator on
		apb(1'b1, `CRS_OFF_IEN, 32'h2);
		pulse(0);
		repeat (2) @(posedge clock_i);
		chk("bor_hold", 1, crst);
		wait_run(n);
		chk("bor_dly", 1, n >= 2490 && n <= 2520);
		apb(1'b0, `CRS_OFF_RCTL, 32'h0);
		chk("bor_flag", 1, rd[`CRS_BOR_BIT]);
		chk("irq_set", 1, irq);
		apb(1'b1, `CRS_OFF_ICLR, 32'h2);
		repeat (2) @(posedge clock_i);
		chk("irq_clr", 0, irq);
		// sleep and wake for each regulator and keep setting
		for (int i = 0; i < 4; i++)
		begin
			ren <= srow[i].r;
			apb(1'b1, `CRS_OFF_RCTL, {23'h0, srow[i].k, 8'h03});
			apb(1'b0, `CRS_OFF_RCTL, 32'h0);
			chk("keep_bit", srow[i].k, rd[`CRS_KEEP_BIT]);
			pulse(1);
			repeat (3) @(posedge clock_i);
			chk("standby", srow[i].s, stby);
			chk("flash_pwr", !srow[i].s, fpwr);
			chk("sleep_exec", 0, exe);
			pulse(2);
			wait_run(n);
			chk("wake_dly", 1, n >= srow[i].lo && n <= srow[i].hi);
		end
		// erased words with regulator off
		ren <= 1'b0;
		pulse(3);
		pulse(4);
		repeat (2) @(posedge clock_i);
		chk("por_hold", 1, crst);
		wait_run(n);
		chk("por_powerup_delay_timer", 1, n >= 20 && n <= 60);
		chk("cprot", 1, cprot);
		// other reset source: reload again, no start delay
		pulse(5);
		repeat (2) @(posedge clock_i);
		chk("orst_hold", 1, crst);
		wait_run(n);
		chk("orst_dly", 1, n >= 1 && n <= 12);
		chk("orst_cprot", 1, cprot);
		// clock enable low freezes the sequencer
		ce <= 1'b0;
		pulse(1);
		repeat (2) @(posedge clock_i);
		chk("ce_freeze", 1, exe);
		ce <= 1'b1;
		// second reset in mid-run
		@(posedge clock_i);
		rst_b_i <= 1'b0;
		@(posedge clock_i);
		rst_b_i <= 1'b1;
		@(posedge clock_i);
		chk("rst_exec", 0, exe);
		wait_run(n);
		chk("rst_run", 1, exe);
		tally_and_finish;
	end
endmodule

`default_nettype wire
